// file: logic/mri_core.sv
// Purpose: processor core end; turns register commands into link requests
// Assumes: software keeps to the plain register port timing
// Notes:   one request outstanding at a time; illegal combinations refused
`timescale 1ns/1ps
module mri_core (
   input  wire  logic               clk,
   input  wire  logic               sys_rst,
   input  wire  mri_pkg::mri_raddr_t reg_addr,
   input  wire  mri_pkg::mri_word_t reg_wdata,
   input  wire  logic               reg_we,
   input  wire  logic               reg_re,
   output var   mri_pkg::mri_word_t reg_rdata,
   mri_if.core                      lnk
);
   import mri_pkg::*;

   typedef enum logic [2:0] {
      cs_idle = 3'b001,
      cs_out  = 3'b010,
      cs_w1   = 3'b100
   } mri_cst_t;

   typedef struct packed {
      mri_cst_t   st;
      logic       ph2;
      logic       stalled;
      logic       go;
      logic       refused;
      logic       big;
      mri_word_t  addr;
      mri_word_t  wdata;
      mri_areq_t  c_areq;
      mri_rreqd_t c_rqd;
      logic       c_ic;
      logic       c_ip;
      logic       c_more;
      mri_areq_t  l_areq;
      logic       l_more;
      mri_word_t  l_vaddr;
      mri_word_t  l_wdata;
      logic       l_ic;
      logic       l_ip;
      mri_rreqd_t l_rqd;
      mri_aresp_t aresp;
      mri_rresp_t rresp;
      mri_word_t  rd0;
      mri_word_t  rd1;
      logic [1:0] off;
      logic       half;
      mri_word_t  rdata;
   } mri_core_t;

   mri_core_t r;
   mri_core_t n;
   mri_word_t pick_val;

   // ==========================================================
   // allowed request combinations
   function automatic logic legal(input logic [2:0] a, input logic [1:0] d,
                                  input logic i);
      legal = 1'b0;
      if (d <= rreqd_two) begin
         case (a)
            access_idle:        legal = 1'b1;
            access_word_store:  legal = (d == rreqd_none);
            access_instr_fetch: legal = (d == rreqd_none) && i;
            access_data_load, access_data_load_seq,
            access_byte_load, access_halfword_load:
                                legal = (d != rreqd_none) && !i;
            default:            legal = 1'b0;
         endcase
      end
   endfunction

   mri_lane u_pick (
      .word_in  (r.rd0),
      .offset   (r.off),
      .half     (r.half),
      .pick_big (r.big),
      .put_big  (r.big),
      .value    (pick_val),
      .placed   ()
   );

   // ==========================================================
   // next state
   always_comb begin
      n = r;
      // phase stops in phase 2 while confirm is high
      n.stalled = r.ph2 && lnk.resp_confirm;
      n.ph2 = n.stalled ? 1'b1 : !r.ph2;
      if (reg_we) begin
         case (reg_addr)
            REG_CTRL:   n.big = reg_wdata[CTRL_BIG_BIT];
            REG_ADDR:   n.addr = reg_wdata;
            REG_WDATA:  n.wdata = reg_wdata;
            REG_CMD: begin
               if (r.go || r.st != cs_idle ||
                   !legal(reg_wdata[CMD_AREQ_LSB +: 3], reg_wdata[CMD_RQD_LSB +: 2],
                          reg_wdata[CMD_IC_BIT] | reg_wdata[CMD_IP_BIT])) begin
                  n.refused = 1'b1;
               end else begin
                  n.go = 1'b1;
                  n.c_areq = mri_areq_t'(reg_wdata[CMD_AREQ_LSB +: 3]);
                  n.c_rqd = mri_rreqd_t'(reg_wdata[CMD_RQD_LSB +: 2]);
                  n.c_ic = reg_wdata[CMD_IC_BIT];
                  n.c_ip = reg_wdata[CMD_IP_BIT];
                  n.c_more = reg_wdata[CMD_MORE_BIT];
               end
            end
            REG_STATUS: if (reg_wdata[ST_REFUSED_BIT]) n.refused = 1'b0;
            default: ;
         endcase
      end
      // read data stands in the cycle after the strobe
      if (reg_re) begin
         n.rdata = '0;
         case (reg_addr)
            REG_CTRL:   n.rdata[CTRL_BIG_BIT] = r.big;
            REG_ADDR:   n.rdata = r.addr;
            REG_WDATA:  n.rdata = r.wdata;
            REG_CMD: begin
               n.rdata[CMD_AREQ_LSB +: 3] = r.c_areq;
               n.rdata[CMD_RQD_LSB +: 2] = r.c_rqd;
               n.rdata[CMD_IC_BIT] = r.c_ic;
               n.rdata[CMD_IP_BIT] = r.c_ip;
               n.rdata[CMD_MORE_BIT] = r.c_more;
            end
            REG_STATUS: begin
               n.rdata[ST_BUSY_BIT] = r.go || (r.st != cs_idle);
               n.rdata[ST_STALL_BIT] = r.stalled;
               n.rdata[ST_REFUSED_BIT] = r.refused;
               n.rdata[ST_ARESP_LSB +: 2] = r.aresp;
               n.rdata[ST_RRESP_LSB +: 3] = r.rresp;
            end
            REG_RDATA0: n.rdata = r.rd0;
            REG_RDATA1: n.rdata = r.rd1;
            REG_PICK:   n.rdata = pick_val;
            default:    n.rdata = '0;
         endcase
      end
      // request engine, stepping only on unstalled phase ends
      case (r.st)
         cs_idle: begin
            if (r.ph2 && !lnk.resp_confirm && r.go) begin
               n.go = 1'b0;
               n.l_areq = r.c_areq;
               n.l_more = r.c_more;
               n.l_vaddr = r.addr;
               n.l_wdata = r.wdata;
               n.l_ic = r.c_ic;
               n.l_ip = r.c_ip;
               n.l_rqd = r.c_rqd;
               n.off = r.addr[1:0];
               n.half = (r.c_areq == access_halfword_load);
               n.st = cs_out;
            end
         end
         cs_out: begin
            // response confirmed: capture it and drop the request
            if (r.ph2 && !lnk.resp_confirm) begin
               n.aresp = lnk.access_resp;
               n.rresp = lnk.return_resp;
               n.rd0 = lnk.rdata;
               n.l_areq = access_idle;
               n.l_more = 1'b0;
               n.l_ic = 1'b0;
               n.l_ip = 1'b0;
               n.l_rqd = rreqd_none;
               n.st = (lnk.return_resp == rresp_data2 ||
                       lnk.return_resp == rresp_instr2) ? cs_w1 : cs_idle;
            end
         end
         cs_w1: begin
            // second word at end of the following phase 1
            if (!r.ph2) begin
               n.rd1 = lnk.rdata;
               n.st = cs_idle;
            end
         end
         default: n.st = cs_idle;
      endcase
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r <= '0;
         r.st <= cs_idle;
         r.big <= RST_BIG;
      end else begin
         r <= n;
      end
   end

   // outputs straight from state
   assign reg_rdata = r.rdata;
   assign lnk.phase2 = r.ph2;
   assign lnk.access_request_type = r.l_areq;
   assign lnk.access_more = r.l_more;
   assign lnk.vaddr = r.l_vaddr;
   assign lnk.wdata = r.l_wdata;
   assign lnk.instr_return_req_core = r.l_ic;
   assign lnk.instr_return_req_prefetch = r.l_ip;
   assign lnk.data_return_req_type = r.l_rqd;
   assign lnk.big_endian = r.big;
endmodule

// file: logic/mri_if.sv
// Purpose: link between processor core end and memory system end
// Assumes: both ends clocked by the same clk
// Notes:   phase2 comes from the core, whose phase may stall in phase 2
`timescale 1ns/1ps
interface mri_if;
   import mri_pkg::*;

   // ==========================================================
   // request side, core to memory
   logic       phase2;
   mri_areq_t  access_request_type;
   logic       access_more;
   mri_word_t  vaddr;
   mri_word_t  wdata;
   logic       instr_return_req_core;
   logic       instr_return_req_prefetch;
   mri_rreqd_t data_return_req_type;
   logic       big_endian;

   // ==========================================================
   // response side, memory to core
   mri_aresp_t access_resp;
   mri_rresp_t return_resp;
   mri_word_t  rdata;
   logic       resp_confirm;

   modport core (output phase2, access_request_type, access_more, vaddr, wdata,
                 instr_return_req_core, instr_return_req_prefetch,
                 data_return_req_type, big_endian,
                 input access_resp, return_resp, rdata, resp_confirm);
   modport mem  (input phase2, access_request_type, access_more, vaddr, wdata,
                 instr_return_req_core, instr_return_req_prefetch,
                 data_return_req_type, big_endian,
                 output access_resp, return_resp, rdata, resp_confirm);
endinterface

// file: logic/mri_lane.sv
// Purpose: byte and halfword lane picking and placing on the read bus
// Assumes: word_in is a full read word; offset is address modulo 4
// Notes:   value is zero extended; placed carries zeros outside the lane
`timescale 1ns/1ps
module mri_lane (
   input  wire  mri_pkg::mri_word_t word_in,
   input  wire  logic [1:0]         offset,
   input  wire  logic               half,
   input  wire  logic               pick_big,
   input  wire  logic               put_big,
   output var   mri_pkg::mri_word_t value,
   output var   mri_pkg::mri_word_t placed
);
   import mri_pkg::*;

   // ==========================================================
   // lane number in bytes; halfword offsets 1 and 3 are undefined
   function automatic logic [1:0] lane_of(input logic [1:0] off,
                                          input logic half_w,
                                          input logic big);
      if (half_w)
         lane_of = {off[1] ^ big, 1'b0};
      else
         lane_of = big ? 2'h3 - off : off;
   endfunction

   logic [4:0] pick_sh;
   logic [4:0] put_sh;

   // shift amounts from byte lanes
   assign pick_sh = {lane_of(offset, half, pick_big), 3'h0};
   assign put_sh  = {lane_of(offset, half, put_big), 3'h0};

   // other bits are don't care to the core, so they stay zero
   always_comb begin
      value = word_in >> pick_sh;
      value = half ? {16'h0000, value[15:0]} : {24'h00_0000, value[7:0]};
      placed = value << put_sh;
   end
endmodule

// file: logic/mri_mem.sv
// Purpose: memory system end; serves link requests from word buffers
// Assumes: user memory answers mem_req with mem_ack and mem_rdata together
// Notes:   no cache: every access request misses and raises confirm
//
// Behaviour
// - core issues requests at end of phase 2
// - response set by phase 1, stable phase 2
// - core issues next requests by next phase 2
// - response provisional, confirm high means wrong
// - confirm high holds core in phase 2
// - correct response first, then confirm drops
// - misses and uncacheable accesses raise confirm
// - access carries 32-bit address and write data
// - return words at phase 2 end, phase 1
// - linked access and return load then return
// - singles: buffered returns or a store
// - parallel pair only store plus instruction return
// - multiple-transfer variant flags more words follow
// - sequential load uses memory's own incrementer
// - byte lane chosen by offset and endianness
// - halfword lanes by offset; odd offsets undefined
// - instruction return is two words; data first
// - store word driven phase 1 after request
// - data return asks zero, one or two words
`timescale 1ns/1ps
module mri_mem (
   input  wire  logic               clk,
   input  wire  logic               sys_rst,
   mri_if.mem                       lnk,
   output logic                     mem_req,
   output logic                     mem_we,
   output var   mri_pkg::mri_word_t mem_addr,
   output var   mri_pkg::mri_word_t mem_wdata,
   input  wire  mri_pkg::mri_word_t mem_rdata,
   input  wire  logic               mem_ack
);
   import mri_pkg::*;

   typedef enum logic [2:0] {
      ms_idle = 3'b001,
      ms_mem  = 3'b010,
      ms_done = 3'b100
   } mri_mst_t;

   typedef struct packed {
      mri_mst_t        st;
      mri_areq_t       areq;
      logic            more;
      mri_word_t       addr;
      logic            rq_i;
      mri_rreqd_t      rqd;
      logic            use_i;
      logic            confirm;
      mri_aresp_t      aresp;
      mri_rresp_t      rresp;
      mri_word_t       rdata;
      logic [1:0][31:0] dbuf;
      logic [1:0][31:0] ibuf;
      logic            dval;
      logic            ival;
      mri_word_t       dseq;
      logic            wcnt;
      logic            two;
      logic            mreq;
      logic            mwe;
      mri_word_t       maddr;
      mri_word_t       mwdata;
   } mri_mem_t;

   mri_mem_t  r;
   mri_mem_t  n;
   mri_word_t placed;

   // ==========================================================
   // return answer; data wins over instructions
   function automatic mri_rresp_t answer(input mri_rreqd_t d, input logic i,
                                         input logic dv, input logic iv);
      if (d != rreqd_none)
         answer = !dv ? rresp_nothing : (d == rreqd_two) ? rresp_data2
                                                         : rresp_data1;
      else if (i)
         answer = iv ? rresp_instr2 : rresp_nothing;
      else
         answer = rresp_nothing;
   endfunction

   // sub-word loads are moved to the lane the core expects
   mri_lane u_place (
      .word_in  (mem_rdata),
      .offset   (r.addr[1:0]),
      .half     (r.areq == access_halfword_load),
      .pick_big (1'b0),
      .put_big  (lnk.big_endian),
      .value    (),
      .placed   (placed)
   );

   // ==========================================================
   // next state
   always_comb begin
      n = r;
      // unstalled end of phase 2: show second word
      if (lnk.phase2 && !r.confirm) begin
         n.rdata = r.use_i ? r.ibuf[1] : r.dbuf[1];
      end
      case (r.st)
         ms_idle: begin
            // end of phase 1: the request issued at the last phase 2 end stands on
            // the link now; answering here keeps the answer stable through phase 2
            if (!lnk.phase2) begin
               n.areq = lnk.access_request_type;
               n.more = lnk.access_more;
               n.addr = lnk.vaddr;
               n.rq_i = lnk.instr_return_req_core | lnk.instr_return_req_prefetch;
               n.rqd = lnk.data_return_req_type;
               if (n.areq != access_idle) begin
                  // no cache, so every access is a miss: hold the core
                  n.confirm = 1'b1;
                  n.aresp = aresp_notdone;
                  n.rresp = rresp_nothing;
                  n.st = ms_mem;
                  n.wcnt = 1'b0;
                  n.mreq = 1'b1;
                  n.mwe = (n.areq == access_word_store);
                  n.mwdata = lnk.wdata;
                  n.maddr = (n.areq == access_data_load_seq) ? r.dseq
                            : {n.addr[31:2], 2'h0};
                  n.two = (n.areq == access_instr_fetch) ||
                          ((n.areq == access_data_load ||
                            n.areq == access_data_load_seq) &&
                           n.rqd == rreqd_two);
               end else begin
                  // return only: serve from what the buffers hold
                  n.aresp = aresp_notdone;
                  n.rresp = answer(n.rqd, n.rq_i, r.dval, r.ival);
                  n.use_i = (n.rqd == rreqd_none);
                  n.rdata = n.use_i ? r.ibuf[0] : r.dbuf[0];
               end
            end
         end
         ms_mem: begin
            if (mem_ack) begin
               case (r.areq)
                  access_instr_fetch:   n.ibuf[r.wcnt] = mem_rdata;
                  access_byte_load,
                  access_halfword_load: n.dbuf[0] = placed;
                  access_word_store:    n.dbuf = r.dbuf;
                  default:              n.dbuf[r.wcnt] = mem_rdata;
               endcase
               if (r.two && !r.wcnt) begin
                  // own incrementer for the second buffer word
                  n.wcnt = 1'b1;
                  n.maddr = r.maddr + WORD_STEP;
               end else begin
                  n.mreq = 1'b0;
                  n.mwe = 1'b0;
                  n.st = ms_done;
                  n.aresp = aresp_done;
                  if (r.areq == access_instr_fetch) begin
                     n.ival = 1'b1;
                  end else if (r.areq != access_word_store) begin
                     n.dval = 1'b1;
                     n.dseq = r.maddr + WORD_STEP;
                  end
                  // linked pair returns the words just loaded
                  n.rresp = answer(r.rqd, r.rq_i, n.dval, n.ival);
                  n.use_i = (r.rqd == rreqd_none);
                  n.rdata = n.use_i ? n.ibuf[0] : n.dbuf[0];
               end
            end
         end
         ms_done: begin
            // correct response already stands; now release the core
            n.confirm = 1'b0;
            n.st = ms_idle;
         end
         default: n.st = ms_idle;
      endcase
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r <= '0;
         r.st <= ms_idle;
      end else begin
         r <= n;
      end
   end

   // outputs straight from state
   assign lnk.access_resp = r.aresp;
   assign lnk.return_resp = r.rresp;
   assign lnk.rdata = r.rdata;
   assign lnk.resp_confirm = r.confirm;
   assign mem_req = r.mreq;
   assign mem_we = r.mwe;
   assign mem_addr = r.maddr;
   assign mem_wdata = r.mwdata;
endmodule

// file: logic/mri_pkg.sv
// Purpose: shared types and constants of the core/memory request link
// Assumes: one 25 MHz clock; each clk cycle is one phase of the two-phase scheme
// Notes:   encodings below are fixed for both ends of the link
package mri_pkg;

   // ==========================================================
   // link types
   typedef logic [31:0] mri_word_t;
   typedef logic [2:0]  mri_raddr_t;

   // access request codes, agreed by both ends
   typedef enum logic [2:0] {
      access_idle          = 3'h0,
      access_data_load     = 3'h1,
      access_data_load_seq = 3'h2,
      access_byte_load     = 3'h3,
      access_halfword_load = 3'h4,
      access_word_store    = 3'h5,
      access_instr_fetch   = 3'h6
   } mri_areq_t;

   // data return request: zero, one or two words
   typedef enum logic [1:0] {
      rreqd_none = 2'h0,
      rreqd_one  = 2'h1,
      rreqd_two  = 2'h2
   } mri_rreqd_t;

   typedef enum logic [1:0] {
      aresp_notdone = 2'h0,
      aresp_abort   = 2'h1,
      aresp_done    = 2'h2
   } mri_aresp_t;

   typedef enum logic [2:0] {
      rresp_nothing    = 3'h0,
      rresp_extabort_d = 3'h1,
      rresp_extabort_i = 3'h2,
      rresp_data1      = 3'h3,
      rresp_data2      = 3'h4,
      rresp_instr1     = 3'h5,
      rresp_instr2     = 3'h6
   } mri_rresp_t;

   // ==========================================================
   // core register map and fields
   localparam mri_raddr_t REG_CTRL   = 3'h0;
   localparam mri_raddr_t REG_ADDR   = 3'h1;
   localparam mri_raddr_t REG_WDATA  = 3'h2;
   localparam mri_raddr_t REG_CMD    = 3'h3;
   localparam mri_raddr_t REG_STATUS = 3'h4;
   localparam mri_raddr_t REG_RDATA0 = 3'h5;
   localparam mri_raddr_t REG_RDATA1 = 3'h6;
   localparam mri_raddr_t REG_PICK   = 3'h7;

   localparam int CTRL_BIG_BIT   = 0;
   localparam int CMD_AREQ_LSB   = 0;
   localparam int CMD_RQD_LSB    = 3;
   localparam int CMD_IC_BIT     = 5;
   localparam int CMD_IP_BIT     = 6;
   localparam int CMD_MORE_BIT   = 7;
   localparam int ST_BUSY_BIT    = 0;
   localparam int ST_STALL_BIT   = 1;
   localparam int ST_REFUSED_BIT = 2;
   localparam int ST_ARESP_LSB   = 3;
   localparam int ST_RRESP_LSB   = 5;

   localparam logic      RST_BIG   = 1'h0;
   localparam mri_word_t WORD_STEP = 32'h0000_0004;

endpackage

// file: tb/mri_sva.sv
// Purpose: protocol checker on the core/memory request link
// Assumes: one clock, sync reset active high
// Notes:   sees interface signals only
`timescale 1ns/1ps
module mri_sva (
   input wire logic                clk,
   input wire logic                sys_rst,
   input wire logic                phase2,
   input wire mri_pkg::mri_areq_t  access_request_type,
   input wire mri_pkg::mri_word_t  vaddr,
   input wire logic                instr_return_req_core,
   input wire logic                instr_return_req_prefetch,
   input wire mri_pkg::mri_rreqd_t data_return_req_type,
   input wire mri_pkg::mri_aresp_t access_resp,
   input wire mri_pkg::mri_rresp_t return_resp,
   input wire logic                resp_confirm
);
   import mri_pkg::*;
   // ==========================================================
   // link properties
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // corrected answer must already stand when confirm falls
   sequence s_fixed;
      $stable(access_resp) && $stable(return_resp) && access_resp == aresp_done;
   endsequence
   // bound on the stall, so a stuck confirm is seen
   sequence s_release;
      ##[1:40] !resp_confirm;
   endsequence
   a_phase_one: assert property (!phase2 |=> phase2)
      else $error("phase 1 not followed by phase 2");
   a_phase_run: assert property (phase2 && !resp_confirm |=> !phase2)
      else $error("phase 2 did not end without confirm");
   a_stall_hold: assert property (phase2 && resp_confirm |=> phase2)
      else $error("core left phase 2 while confirm high");
   a_issue_end_p2: assert property (access_request_type != access_idle &&
      $past(access_request_type) == access_idle |-> $past(phase2) && !$past(resp_confirm))
      else $error("request issued outside end of phase 2");
   a_req_held: assert property (resp_confirm |->
      $stable(access_request_type) && $stable(vaddr))
      else $error("request changed during stall");
   a_confirm_ends: assert property ($rose(resp_confirm) |-> s_release)
      else $error("confirm held too long");
   a_resp_first: assert property ($fell(resp_confirm) |-> s_fixed)
      else $error("confirm fell before correct response");
   a_confirm_cause: assert property ($rose(resp_confirm) |->
      access_request_type != access_idle)
      else $error("confirm raised with no access");
   a_store_pair: assert property (access_request_type == access_word_store |->
      data_return_req_type == rreqd_none)
      else $error("store paired with data return");
   a_load_pair: assert property (access_request_type inside {access_data_load,
      access_data_load_seq, access_byte_load, access_halfword_load} |->
      !instr_return_req_core && !instr_return_req_prefetch)
      else $error("load paired with instruction return");
endmodule

// file: tb/tb_core_memory_request_interface.sv
// Purpose: self-checking bench, core end facing memory end
// Assumes: user memory answers one cycle after a request; a second buffer word waits two cycles
// Notes:   read word pattern is address xor a constant
`timescale 1ns/1ps
module tb_core_memory_request_interface;
   import mri_pkg::*;
   logic       clk, sys_rst, reg_we, reg_re, mem_req, mem_we, mem_ack;
   mri_raddr_t reg_addr;
   mri_word_t  reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, st_addr, st_data, got;
   int         miscompares, compares;
   mri_if lnk ();
   mri_core u_mri_core (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
      .lnk(lnk.core));
   mri_mem u_mri_mem (.clk(clk), .sys_rst(sys_rst), .lnk(lnk.mem), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack));
   mri_sva u_mri_sva (.clk(clk), .sys_rst(sys_rst), .phase2(lnk.phase2),
      .access_request_type(lnk.access_request_type), .vaddr(lnk.vaddr),
      .instr_return_req_core(lnk.instr_return_req_core),
      .instr_return_req_prefetch(lnk.instr_return_req_prefetch),
      .data_return_req_type(lnk.data_return_req_type), .access_resp(lnk.access_resp),
      .return_resp(lnk.return_resp), .resp_confirm(lnk.resp_confirm));
   // ==========================================================
   // user memory: slow ack, so every access stalls a while
   always @(posedge clk) begin
      mem_ack   <= mem_req && !mem_ack && !sys_rst;
      mem_rdata <= patt(mem_addr);
      if (mem_req && mem_ack && mem_we) begin
         st_addr <= mem_addr;
         st_data <= mem_wdata;
      end
   end
   function automatic mri_word_t patt(input mri_word_t a);
      return a ^ 32'h5A5A_0F0F;
   endfunction
   // ==========================================================
   // bus and compare tasks
   task automatic check(input string what, input mri_word_t exp, input mri_word_t seen);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input mri_raddr_t a, input mri_word_t d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_we    <= 1'b1;
      reg_re    <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input mri_raddr_t a);
      reg_addr <= a;
      reg_we   <= 1'b0;
      reg_re   <= 1'b1;
      @(posedge clk);
      reg_re <= 1'b0;
      #1 got = reg_rdata;
      @(posedge clk);
   endtask
   // issue a command, poll busy with a bound, judge both responses
   task automatic go(input mri_word_t cmd, input mri_rresp_t exp);
      int n = 0;
      wr(REG_CMD, cmd);
      do begin
         rd(REG_STATUS);
         n++;
      end while (got[ST_BUSY_BIT] !== 1'b0 && n < 60);
      if (got[ST_BUSY_BIT] !== 1'b0) begin
         miscompares++;
         complete_run();
      end
      check("access response", 32'(aresp_done), 32'(got[ST_ARESP_LSB +: 2]));
      check("return response", 32'(exp), 32'(got[ST_RRESP_LSB +: 3]));
   endtask
   // ==========================================================
   // scenarios
   task automatic t_store();
      wr(REG_WDATA, 32'hC0DE_1234);
      wr(REG_ADDR, 32'h0000_0200);
      go(32'h0000_0025, rresp_nothing);
      check("store word", 32'hC0DE_1234, st_data);
      check("store address", 32'h0000_0200, st_addr);
      wr(REG_ADDR, 32'h0000_0400);
      go(32'h0000_0026, rresp_instr2);
      rd(REG_RDATA0);
      check("fetched word", patt(32'h0000_0400), got);
   endtask
   task automatic t_load();
      wr(REG_ADDR, 32'h0000_0100);
      go(32'h0000_0011, rresp_data2);
      rd(REG_RDATA0);
      check("word 0", patt(32'h0000_0100), got);
      rd(REG_RDATA1);
      check("word 1", patt(32'h0000_0104), got);
      go(32'h0000_008A, rresp_data1);
      rd(REG_RDATA0);
      check("sequential word", patt(32'h0000_0108), got);
   endtask
   // every lane of byte and halfword, both byte orders
   task automatic t_lanes();
      mri_word_t w, exp;
      w = patt(32'h0000_0300);
      for (int h = 0; h < 2; h++)
         for (int b = 0; b < 2; b++)
            for (int o = 0; o < 4; o += h + 1) begin
               exp = h ? (w >> (8 * o)) & 32'h0000_FFFF : (w >> (8 * o)) & 32'h0000_00FF;
               wr(REG_CTRL, 32'(b));
               wr(REG_ADDR, 32'h0000_0300 + 32'(o));
               go(h ? 32'h0000_000C : 32'h0000_000B, rresp_data1);
               rd(REG_PICK);
               check("picked lane", exp, got);
               rd(REG_RDATA0);
               check("placed lane", exp << (b ? (h ? 16 - 8 * o : 24 - 8 * o) : 8 * o), got);
            end
   endtask
   // illegal pairings refused, flag cleared by write
   task automatic t_refuse();
      mri_word_t bad[3] = '{32'h0000_0021, 32'h0000_000D, 32'h0000_0001};
      foreach (bad[i]) begin
         wr(REG_CMD, bad[i]);
         rd(REG_STATUS);
         check("refused flag", 32'h0000_0004, got & 32'h0000_0005);
         wr(REG_STATUS, 32'h0000_0004);
         rd(REG_STATUS);
         check("refused cleared", 32'h0000_0000, got & 32'h0000_0004);
      end
   endtask
   task automatic complete_run();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ==========================================================
   // clock and main sequence
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      {sys_rst, reg_we, reg_re} = 3'h4;
      {reg_addr, reg_wdata} = '0;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_store();
      t_load();
      t_lanes();
      t_refuse();
      complete_run();
   end
endmodule
